// [src/rtc_pkg.sv]
// Package: register map, field layout and encodings for readout timing control
package rtc_pkg;
   localparam logic [7:0] ADDR_MARKER_WIDTH = 8'h56;
   localparam logic [7:0] ADDR_SCAN_CTRL = 8'h57;
   localparam logic [7:0] ADDR_SHS_WIDTH = 8'h5F;
   localparam logic [7:0] ADDR_SHR_WIDTH = 8'h60;

   localparam logic [7:0] RST_MARKER_WIDTH = 8'h0E;
   localparam logic [7:0] RST_SCAN_CTRL = 8'h04;
   localparam logic [7:0] RST_SHS_WIDTH = 8'h0A;
   localparam logic [7:0] RST_SHR_WIDTH = 8'h0A;

   localparam logic [7:0] MASK_MARKER_WIDTH = 8'h0F;
   localparam logic [7:0] MASK_SCAN_CTRL = 8'h0F;
   localparam logic [7:0] MASK_SAMPLE_WIDTH = 8'h3F;

   localparam int FRAME_LEN_LSB = 2;
   localparam int ROW_LEN_LSB = 0;
   localparam int BIT_COL_REVERSE = 0;
   localparam int BIT_ROW_REVERSE = 1;
   localparam int BIT_COL_GRAY = 2;
   localparam int BIT_ROW_GRAY = 3;

   localparam int SAMPLE_W = 6;
   localparam int WIDTH_CNT_W = 7;

   typedef enum logic [1:0]
   {
      LEN_ONE = 2'b00,
      LEN_EIGHT = 2'b01,
      LEN_SIXTYFOUR = 2'b10,
      LEN_FULL_ROW = 2'b11
   } rtc_len_t;

   localparam logic [WIDTH_CNT_W-1:0] LEN_ONE_CLKS = 7'h01;
   localparam logic [WIDTH_CNT_W-1:0] LEN_EIGHT_CLKS = 7'h08;
   localparam logic [WIDTH_CNT_W-1:0] LEN_SIXTYFOUR_CLKS = 7'h40;

   // First member is the MSB, so bit 0 of the register is listed last
   typedef struct packed
   {
      logic rowGray;
      logic colGray;
      logic rowReverse;
      logic colReverse;
   } rtc_scan_t;

   typedef struct packed
   {
      logic wrEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } rtc_reg_req_t;
endpackage

// [src/rtc_pulse_gen.sv]
// Pulse stretcher: one start strobe gives a pulse of a programmed width
`timescale 1ns/1ps
module rtc_pulse_gen
   import rtc_pkg::*;
#(
   parameter int CNT_W = WIDTH_CNT_W
)
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Control
   input wire logic start,
   input wire logic holdMode,
   input wire logic holdEnd,
   input wire logic [CNT_W-1:0] width,
   // Pulse
   output logic pulse
);
   logic [CNT_W-1:0] remain;

   // In hold mode the pulse lasts until holdEnd, ignoring the count
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         remain <= '0;
         pulse <= 1'b0;
      end
      else if (start)
      begin
         remain <= width - CNT_W'(1);
         pulse <= 1'b1;
      end
      else if (holdMode)
      begin
         if (holdEnd)
            pulse <= 1'b0;
      end
      else if (remain != '0)
         remain <= remain - CNT_W'(1);
      else
         pulse <= 1'b0;
   end
endmodule

// [src/readout_timing_ctrl.sv]
// Readout timing control: marker widths, address coding and sample widths
`timescale 1ns/1ps
// Operation
// RL1: Frame-start marker width from bits 3-2: 1, 8, 64 clocks or a full row.
// RL2: Row-valid marker width from bits 1-0 with the same coding, reset 10.
// RL3: Readout control bit 0 reverses column readout, reset 0.
// RL4: Readout control bit 1 reverses row readout, top to bottom when set.
// RL5: Readout control bit 2 selects Gray column addresses, reset 1.
// RL6: Readout control bit 3 selects Gray row addresses, else binary.
// RL7: Signal-sample pulse is field value clocks wide, zero meaning 64.
// RL8: Both sample widths reset to ten clocks field value 001010.
// RL9: Reset-sample width lives at 60h with the same coding, default 0A.
// RL10: By default frame-start spans a full row, row-valid 64 clocks.
// RL11: Unused upper bits ignore writes and read back as zero.
module readout_timing_ctrl
   import rtc_pkg::*;
#(
   parameter int COL_W = 11,
   parameter int ROW_W = 11
)
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Register port from the serial control slave
   input wire rtc_reg_req_t regReq,
   output logic [7:0] regRdData,
   // Timing events from the sequencer
   input wire logic frameStart,
   input wire logic rowStart,
   input wire logic rowEnd,
   input wire logic sampleSigStart,
   input wire logic sampleRstStart,
   // Logical scan position
   input wire logic [COL_W-1:0] colIndex,
   input wire logic [ROW_W-1:0] rowIndex,
   input wire logic [COL_W-1:0] colLast,
   input wire logic [ROW_W-1:0] rowLast,
   // Outputs
   output logic frame_start_marker,
   output logic row_valid_marker,
   output logic sampleSigPulse,
   output logic sampleRstPulse,
   output logic [COL_W-1:0] colAddr,
   output logic [ROW_W-1:0] rowAddr
);
   logic [3:0] markerWidth;
   rtc_scan_t scanCtrl;
   logic [SAMPLE_W-1:0] shsWidth;
   logic [SAMPLE_W-1:0] shrWidth;
   logic [COL_W-1:0] next_colAddr;
   logic [ROW_W-1:0] next_rowAddr;

   function automatic logic [WIDTH_CNT_W-1:0] len_clks(input logic [1:0] code);
      case (rtc_len_t'(code))
         LEN_ONE: len_clks = LEN_ONE_CLKS;
         LEN_EIGHT: len_clks = LEN_EIGHT_CLKS;
         LEN_SIXTYFOUR: len_clks = LEN_SIXTYFOUR_CLKS;
         default: len_clks = LEN_ONE_CLKS;
      endcase
   endfunction

   // One write decode shared by every register
   function automatic logic wr_hit(input rtc_reg_req_t r,
      input logic [7:0] a);
      wr_hit = r.wrEn && (r.addr == a);
   endfunction

   // Zero encodes the longest width, 64 clocks
   function automatic logic [WIDTH_CNT_W-1:0] sample_clks(
      input logic [SAMPLE_W-1:0] v);
      sample_clks = (v == '0) ? LEN_SIXTYFOUR_CLKS : {1'b0, v};
   endfunction

   // Writes: upper bits masked off so they never store
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         markerWidth <= RST_MARKER_WIDTH[3:0]; // RL10
      else if (wr_hit(regReq, ADDR_MARKER_WIDTH))
         markerWidth <= regReq.wrData[3:0] & MASK_MARKER_WIDTH[3:0]; // RL11
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         scanCtrl <= RST_SCAN_CTRL[3:0]; // RL5
      else if (wr_hit(regReq, ADDR_SCAN_CTRL))
         scanCtrl <= regReq.wrData[3:0] & MASK_SCAN_CTRL[3:0]; // RL11
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         shsWidth <= RST_SHS_WIDTH[SAMPLE_W-1:0]; // RL8
         shrWidth <= RST_SHR_WIDTH[SAMPLE_W-1:0]; // RL9
      end
      else if (wr_hit(regReq, ADDR_SHS_WIDTH))
         shsWidth <= regReq.wrData[SAMPLE_W-1:0];
      else if (wr_hit(regReq, ADDR_SHR_WIDTH))
         shrWidth <= regReq.wrData[SAMPLE_W-1:0]; // RL9
   end

   // Read data registered; unmapped addresses and unused bits read zero
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         regRdData <= 8'h00;
      else
         case (regReq.addr)
            ADDR_MARKER_WIDTH: regRdData <= {4'h0, markerWidth}; // RL11
            ADDR_SCAN_CTRL: regRdData <= {4'h0, scanCtrl}; // RL11
            ADDR_SHS_WIDTH: regRdData <= {2'h0, shsWidth};
            ADDR_SHR_WIDTH: regRdData <= {2'h0, shrWidth};
            default: regRdData <= 8'h00;
         endcase
   end

   // Full-row mode holds the marker until the row ends
   rtc_pulse_gen u_frame_pulse (
      .sys_clk(sys_clk),
      .rst(rst),
      .start(frameStart),
      .holdMode(markerWidth[FRAME_LEN_LSB +: 2] == LEN_FULL_ROW), // RL1
      .holdEnd(rowEnd),
      .width(len_clks(markerWidth[FRAME_LEN_LSB +: 2])), // RL1
      .pulse(frame_start_marker)
   );

   rtc_pulse_gen u_row_pulse (
      .sys_clk(sys_clk),
      .rst(rst),
      .start(rowStart),
      .holdMode(markerWidth[ROW_LEN_LSB +: 2] == LEN_FULL_ROW), // RL2
      .holdEnd(rowEnd),
      .width(len_clks(markerWidth[ROW_LEN_LSB +: 2])), // RL2
      .pulse(row_valid_marker)
   );

   rtc_pulse_gen u_shs_pulse (
      .sys_clk(sys_clk),
      .rst(rst),
      .start(sampleSigStart),
      .holdMode(1'b0),
      .holdEnd(1'b0),
      .width(sample_clks(shsWidth)), // RL7
      .pulse(sampleSigPulse)
   );

   rtc_pulse_gen u_shr_pulse (
      .sys_clk(sys_clk),
      .rst(rst),
      .start(sampleRstStart),
      .holdMode(1'b0),
      .holdEnd(1'b0),
      .width(sample_clks(shrWidth)), // RL9
      .pulse(sampleRstPulse)
   );

   // Direction then coding; reversal mirrors against the last index
   always_comb
   begin
      next_colAddr = scanCtrl.colReverse ? colLast - colIndex : colIndex; // RL3
      next_rowAddr = scanCtrl.rowReverse ? rowLast - rowIndex : rowIndex; // RL4
      if (scanCtrl.colGray)
         next_colAddr = next_colAddr ^ (next_colAddr >> 1); // RL5
      if (scanCtrl.rowGray)
         next_rowAddr = next_rowAddr ^ (next_rowAddr >> 1); // RL6
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         colAddr <= '0;
         rowAddr <= '0;
      end
      else
      begin
         colAddr <= next_colAddr;
         rowAddr <= next_rowAddr;
      end
   end
endmodule

// [verif/rtc_capture_model.sv]
// Capture-side model: width of each high run on a marker line
`timescale 1ns/1ps
module rtc_capture_model
(
   // Clock
   input wire logic sys_clk,
   // Marker in, last run width out
   input wire logic marker,
   output logic [7:0] lastLen
);
   logic [7:0] run;
   always_ff @(posedge sys_clk)
   begin
      run <= marker ? run + 8'h01 : 8'h00;
      if (!marker && run != 8'h00)
         lastLen <= run;
   end
endmodule

// [verif/rtc_props.sv]
// Checker: marker widths, signal-sample width, register readback
`timescale 1ns/1ps
module rtc_props
   import rtc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Register port
   input wire rtc_reg_req_t regReq,
   input wire logic [7:0] regRdData,
   // Events
   input wire logic frameStart,
   input wire logic rowStart,
   input wire logic rowEnd,
   input wire logic sampleSigStart,
   // Pulses
   input wire logic frame_start_marker,
   input wire logic row_valid_marker,
   input wire logic sampleSigPulse
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic [7:0] mw, sw;
   logic [6:0] fC, rC, sC, fE, rE, sE;
   logic [1:0] fM, rM;
   function automatic logic [6:0] wid(input logic [1:0] c);
      return c == LEN_ONE ? 7'h01 : c == LEN_EIGHT ? 7'h08 : 7'h40;
   endfunction
   // Mirrors keep the pre-write value, as the port reads old data
   always_ff @(posedge sys_clk)
      if (rst)
         mw <= 8'h0E;
      else if (regReq.wrEn && regReq.addr == ADDR_MARKER_WIDTH)
         mw <= regReq.wrData & 8'h0F;
   always_ff @(posedge sys_clk)
      if (rst)
         sw <= 8'h0A;
      else if (regReq.wrEn && regReq.addr == ADDR_SHS_WIDTH)
         sw <= regReq.wrData & 8'h3F;
   always_ff @(posedge sys_clk)
   begin
      fC <= frameStart ? 7'h00 : fC + 7'(frame_start_marker);
      rC <= rowStart ? 7'h00 : rC + 7'(row_valid_marker);
      sC <= sampleSigStart ? 7'h00 : sC + 7'(sampleSigPulse);
      if (frameStart)
         {fM, fE} <= {mw[3:2], wid(mw[3:2])};
      if (rowStart)
         {rM, rE} <= {mw[1:0], wid(mw[1:0])};
      if (sampleSigStart)
         sE <= sw[5:0] == 6'h00 ? 7'h40 : {1'b0, sw[5:0]};
   end
   AST_FRAME_WIDTH: assert property ($fell(frame_start_marker)
      && fM != 2'b11 |-> fC == fE) else $error("frame width wrong");
   AST_FRAME_ROW: assert property ($fell(frame_start_marker)
      && fM == 2'b11 |-> $past(rowEnd)) else $error("frame end wrong");
   AST_ROW_WIDTH: assert property ($fell(row_valid_marker)
      && rM != 2'b11 |-> rC == rE) else $error("row width wrong");
   AST_ROW_FULL: assert property ($fell(row_valid_marker)
      && rM == 2'b11 |-> $past(rowEnd)) else $error("row end wrong");
   AST_SIG_WIDTH: assert property ($fell(sampleSigPulse)
      |-> sC == sE) else $error("sample width wrong");
   AST_RD_MARK: assert property (regReq.addr == ADDR_MARKER_WIDTH
      |=> regRdData == $past(mw)) else $error("56h readback wrong");
   AST_RD_SHS: assert property (regReq.addr == ADDR_SHS_WIDTH
      |=> regRdData == $past(sw)) else $error("5Fh readback wrong");
   AST_RD_HIGH: assert property (regReq.addr == ADDR_SCAN_CTRL
      |=> regRdData[7:4] == 4'h0) else $error("57h upper bits set");
   AST_RD_NONE: assert property (regReq.addr == 8'h58
      |=> regRdData == 8'h00) else $error("unmapped read not zero");
   CV_ROW: cover property ($fell(row_valid_marker) && rE == 7'h08);
   CV_FULL: cover property ($fell(frame_start_marker) && fM == 2'b11);
   CV_SIG: cover property ($fell(sampleSigPulse) && sE == 7'h40);
endmodule
bind readout_timing_ctrl rtc_props u_props (.*);

// [verif/tb_top.sv]
// Testbench: registers, marker and sample widths, address coding
`timescale 1ns/1ps
module tb_top;
   import rtc_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   rtc_reg_req_t regReq = '0;
   logic [4:0] ev = 5'h00;
   logic [10:0] cI = 11'h005, rI = 11'h007, cL = 11'h064, rL = 11'h3E8;
   logic [10:0] cA, rA, v;
   logic [7:0] q;
   logic [3:0] p;
   logic [7:0] len [4];
   int err_count = 0;
   int num_checks = 0;
   always #25 sys_clk = ~sys_clk;
   readout_timing_ctrl dut_u (.sys_clk(sys_clk), .rst(rst), .regReq(regReq),
      .regRdData(q), .frameStart(ev[0]), .rowStart(ev[1]), .rowEnd(ev[2]),
      .sampleSigStart(ev[3]), .sampleRstStart(ev[4]), .colIndex(cI),
      .rowIndex(rI), .colLast(cL), .rowLast(rL), .frame_start_marker(p[0]),
      .row_valid_marker(p[1]), .sampleSigPulse(p[2]), .sampleRstPulse(p[3]),
      .colAddr(cA), .rowAddr(rA));
   for (genvar g = 0; g < 4; g++)
   begin : cap
      rtc_capture_model m (.sys_clk(sys_clk), .marker(p[g]), .lastLen(len[g]));
   end
   task automatic chk(input string n, input logic [10:0] e, g);
      num_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(negedge sys_clk) regReq = '{1'b1, a, d};
      @(negedge sys_clk) regReq.wrEn = 1'b0;
   endtask
   // Read data lands one cycle after the address
   task automatic rd(input logic [7:0] a);
      @(negedge sys_clk) regReq.addr = a;
      @(negedge sys_clk);
   endtask
   task automatic kick(input logic [4:0] m);
      @(negedge sys_clk) ev = m;
      @(negedge sys_clk) ev = 5'h00;
   endtask
   task automatic t_regs;
      logic [7:0] a [5] = '{8'h56, 8'h57, 8'h5F, 8'h60, 8'h58};
      logic [7:0] e [5] = '{8'h0E, 8'h04, 8'h0A, 8'h0A, 8'h00};
      logic [7:0] f [5] = '{8'h0F, 8'h0F, 8'h3F, 8'h3F, 8'h00};
      for (int i = 0; i < 10; i++)
      begin
         if (i > 4)
            wr(a[i-5], 8'hFF);
         rd(a[i%5]);
         chk("reg", i > 4 ? f[i-5] : e[i], q);
      end
      $display("t_regs done");
   endtask
   task automatic t_mark;
      logic [7:0] w [3] = '{8'h01, 8'h08, 8'h40};
      wr(8'h56, 8'h0E);
      kick(5'h03);
      repeat (20) @(negedge sys_clk);
      kick(5'h04);
      repeat (50) @(negedge sys_clk);
      chk("fullrow", 11'd22, len[0]);
      chk("row64", 11'd64, len[1]);
      for (int i = 0; i < 3; i++)
      begin
         wr(8'h56, 8'(i * 5));
         kick(5'h03);
         repeat (70) @(negedge sys_clk);
         chk("frame", w[i], len[0]);
         chk("row", w[i], len[1]);
      end
      wr(8'h56, 8'h0F);
      kick(5'h03);
      repeat (9) @(negedge sys_clk);
      kick(5'h04);
      repeat (2) @(negedge sys_clk);
      chk("framefull", 11'd11, len[0]);
      chk("rowfull", 11'd11, len[1]);
      $display("t_mark done");
   endtask
   task automatic t_samp;
      logic [7:0] s [3] = '{8'h00, 8'h01, 8'h3F};
      logic [7:0] w [3] = '{8'h40, 8'h01, 8'h3F};
      for (int i = 0; i < 3; i++)
      begin
         wr(8'h5F, s[i]);
         wr(8'h60, s[i]);
         kick(5'h18);
         repeat (70) @(negedge sys_clk);
         chk("shs", w[i], len[2]);
         chk("shr", w[i], len[3]);
      end
      $display("t_samp done");
   endtask
   task automatic t_addr;
      for (int s = 0; s < 16; s++)
      begin
         wr(8'h57, 8'(s));
         repeat (2) @(negedge sys_clk);
         v = s[0] ? cL - cI : cI;
         chk("col", s[2] ? v ^ (v >> 1) : v, cA);
         v = s[1] ? rL - rI : rI;
         chk("row", s[3] ? v ^ (v >> 1) : v, rA);
      end
      $display("t_addr done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(negedge sys_clk);
      rst = 1'b0;
      t_regs;
      t_mark;
      t_samp;
      t_addr;
      wrap_up;
   end
   // About 640 cycles of tests; some thirty times that means a hang
   initial
   begin
      #1000000;
      err_count++;
      wrap_up;
   end
endmodule
